/* File: ccr_defines.vh */
// Constants for the channel change reply and class request framer
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH
// ----------------------------------------
// Confirmation codes
// ----------------------------------------
`define CCR_CC_OK        8'h00
`define CCR_CC_ARRIVE    8'h01
`define CCR_CC_DEPART    8'h02
`define CCR_CC_ALREADY   8'h03
`define CCR_DCI_SUCCESS  8'h00
`define CCR_DCI_REJ_TEMP 8'h03
`define CCR_DCI_REJ_PERM 8'h04
// ----------------------------------------
// Element codes
// ----------------------------------------
`define CCR_T_JUMP       8'h01
`define CCR_ST_LEN       8'h01
`define CCR_ST_LEN_L     8'h04
`define CCR_ST_START     8'h02
`define CCR_ST_START_L   8'h08
`define CCR_T_KEYSEQ     8'h05
`define CCR_T_KEYSEQ_L   8'h01
`define CCR_T_HMAC       8'h06
`define CCR_T_HMAC_L     8'h14
`define CCR_JUMP_L_S     8'h06
`define CCR_JUMP_L_F     8'h10
`define CCR_INIT_REINIT  3'h0
`define CCR_CLASS_CUSTOMER_CONTROLLED_MODEM_FLAG   0
`define CCR_HMAC_BYTES   5'h14
// ----------------------------------------
// Field lengths in bytes
// ----------------------------------------
`define CCR_B_ID         5'h02
`define CCR_B_CODE       5'h01
`define CCR_B_JHDR       5'h02
`define CCR_B_JLEN       5'h06
`define CCR_B_JST        5'h0a
`define CCR_B_KEY        5'h05
`define CCR_B_CLS        5'h04
`define CCR_JST_N        4'ha
`endif

/* File: ccr_byte_ser.v */
// Byte serialiser: shifts a word out most significant byte first
`timescale 1ns/100ps
`include "ccr_defines.vh"
module ccr_byte_ser #(
    parameter W = 64
) (
    input  wire         clock_in,   // System clock
    input  wire         arst_n_in,  // Async reset, active low
    input  wire         load_in,    // Load word
    input  wire [W-1:0] word_in,    // Word to send
    input  wire [3:0]   nbytes_in,  // Bytes to send from the top
    input  wire         adv_in,     // Advance one byte
    output wire [7:0]   byte_out,   // Current byte
    output wire         last_out    // Current byte is the last
);
    reg [W-1:0] sh_q;
    reg [3:0]   cnt_q;

    // Shift register; MSB first keeps the multi-byte order network-style
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sh_q  <= {W{1'b0}};
            cnt_q <= 4'h0;
        end else if (load_in) begin
            sh_q  <= word_in;
            cnt_q <= nbytes_in;
        end else if (adv_in && cnt_q != 4'h0) begin
            sh_q  <= {sh_q[W-9:0], 8'h00};
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign byte_out = sh_q[W-1:W-8];
    assign last_out = (cnt_q == 4'h1);
endmodule // ccr_byte_ser

/* File: ccr_framer.v */
// Channel change reply and class request framer (modem side)
// Notes on behaviour
// [RULE_01] Headend may send destination address element
// [RULE_02] Headend includes address when retuning downstream
// [RULE_03] First reply goes out before retuning
// [RULE_04] Same channels: reply already-on-channel code
// [RULE_05] Requests during a change are dropped
// [RULE_06] Second reply unless MAC re-initialised
// [RULE_07] Reply holds transaction id then code
// [RULE_08] Privacy adds key sequence, digest last
// [RULE_09] Reply element codes are message local
// [RULE_10] Jump times counted in 10.24 MHz ticks
// [RULE_11] Jump length sub-element always present
// [RULE_12] Optional start time holds start, accuracy
// [RULE_13] Headend treats small start as wrapped
// [RULE_14] Headend outage window uses start, accuracy, length
// [RULE_15] Headend acknowledges arrive replies
// [RULE_16] Acknowledge echoes id, privacy digest last
// [RULE_17] Class request right after ranging complete
// [RULE_18] Initialisation waits for class reply
// [RULE_19] Class request carries ranging identifier
// [RULE_20] Class field: bit 0 flag, rest zero
// [RULE_21] Class reply code: resend, abandon, continue
// [RULE_22] Elements: type, length, value, MSB first
`timescale 1ns/100ps
`include "ccr_defines.vh"
module ccr_framer #(
    parameter CLASS_RETRY_MAX = 8'h03
) (
    input  wire         clock_in,            // 10 MHz system clock
    input  wire         arst_n_in,           // Async reset, active low
    input  wire         chg_req_in,          // Channel change request pulse
    input  wire [15:0]  chg_txn_id_in,       // Transaction id of request
    input  wire         chg_same_chan_in,    // Request names current channels
    input  wire [2:0]   chg_init_opt_in,     // Initialization option of request
    input  wire         retune_done_in,      // Retune finished pulse
    input  wire         privacy_en_in,       // Privacy enabled
    input  wire [7:0]   key_seq_in,          // Auth key sequence number
    input  wire [159:0] hmac_in,             // Digest for current message
    input  wire         jump_start_en_in,    // Include start-time sub-element
    input  wire [31:0]  jump_len_in,         // Jump length in timestamp ticks
    input  wire [31:0]  jump_start_in,       // Planned start timestamp
    input  wire [31:0]  jump_acc_in,         // Start accuracy in ticks
    input  wire         ranging_done_in,     // Ranging complete pulse
    input  wire [13:0]  service_identifier_in, // Temporary id from ranging
    input  wire         customer_controlled_modem_flag_in, // Class bit 0
    input  wire         class_reply_in,      // Class reply received pulse
    input  wire [7:0]   class_reply_code_in, // Class reply confirmation code
    input  wire         class_timeout_in,    // Class reply timer expired pulse
    input  wire         tx_ready_in,         // Upstream accepts a byte
    output reg          tx_valid_out,        // Byte valid
    output reg  [7:0]   tx_byte_out,         // Message byte
    output reg          tx_last_out,         // Last byte of message
    output reg          tx_is_class_out,     // Message is a class request
    output reg          retune_go_out,       // Start retuning pulse
    output reg          chg_busy_out,        // Channel change in progress
    output reg          init_hold_out,       // Initialisation held
    output reg          reg_continue_out,    // Registration may continue pulse
    output reg          rescan_out           // Abandon and rescan pulse
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_SEND = 3'h1;
    localparam S_WAIT = 3'h2;
    localparam S_TUNE = 3'h3;
    localparam S_DCIW = 3'h4;
    // Message field steps
    localparam F_ID   = 4'h0;
    localparam F_CODE = 4'h1;
    localparam F_JHDR = 4'h2;
    localparam F_JLEN = 4'h3;
    localparam F_JST  = 4'h4;
    localparam F_KEY  = 4'h5;
    localparam F_HMAC = 4'h6;
    localparam F_SID  = 4'h7;
    localparam F_CLS  = 4'h8;
    localparam F_DONE = 4'h9;

    reg [2:0]   st_q;
    reg [3:0]   fld_q;
    reg [15:0]  txn_q;
    reg [7:0]   code_q;
    reg         second_q;
    reg         is_class_q;
    reg [7:0]   retry_q;
    reg [4:0]   hcnt_q;
    reg [159:0] hmac_q;
    reg [3:0]   nf;
    reg [4:0]   nc;
    reg [7:0]   nb;
    reg [159:0] nw;
    wire [7:0]  ser_byte;
    wire        adv     = tx_valid_out & tx_ready_in;
    wire        ser_ld  = (st_q == S_IDLE) && chg_req_in && !ranging_done_in;
    wire        ser_adv = adv && (st_q == S_SEND) && !tx_last_out && (nf == F_JST);

    // Start-time element is captured with the request so it cannot shift mid-message
    ccr_byte_ser #(.W(80)) u_ser (
        .clock_in  (clock_in),
        .arst_n_in (arst_n_in),
        .load_in   (ser_ld),
        .word_in   ({`CCR_ST_START, `CCR_ST_START_L, jump_start_in, jump_acc_in}),
        .nbytes_in (`CCR_JST_N),
        .adv_in    (ser_adv),
        .byte_out  (ser_byte),
        .last_out  ()
    );

    // ----------------------------------------
    // Next field and its content
    // ----------------------------------------
    // Field order fixes the digest as the final element of every reply sent with privacy enabled
    function [3:0] nxt;
        input [3:0] f;
        begin
            case (f)
                F_ID:    nxt = F_CODE;
                F_CODE:  nxt = second_q ? (privacy_en_in ? F_KEY : F_DONE) : F_JHDR;
                F_JHDR:  nxt = F_JLEN;
                F_JLEN:  nxt = jump_start_en_in ? F_JST : (privacy_en_in ? F_KEY : F_DONE);
                F_JST:   nxt = privacy_en_in ? F_KEY : F_DONE;
                F_KEY:   nxt = F_HMAC;
                F_SID:   nxt = F_CLS;
                default: nxt = F_DONE;
            endcase
        end
    endfunction

    // Bytes in each field
    function [4:0] flen;
        input [3:0] f;
        begin
            case (f)
                F_ID:    flen = `CCR_B_ID;
                F_SID:   flen = `CCR_B_ID;
                F_CODE:  flen = `CCR_B_CODE;
                F_JHDR:  flen = `CCR_B_JHDR;
                F_JLEN:  flen = `CCR_B_JLEN;
                F_JST:   flen = `CCR_B_JST;
                F_KEY:   flen = `CCR_B_KEY;
                F_HMAC:  flen = `CCR_HMAC_BYTES;
                F_CLS:   flen = `CCR_B_CLS;
                default: flen = 5'h0;
            endcase
        end
    endfunction

    // Byte i of an n-byte field held in the low end of w, top byte first
    function [7:0] pick;
        input [159:0] w;
        input [4:0]   n;
        input [4:0]   i;
        begin
            pick = (n > i) ? w[8*(n-i-5'h1) +: 8] : 8'h0;
        end
    endfunction

    // Next byte to show: its field, its index and its value
    always @* begin
        nf = (hcnt_q == flen(fld_q) - 5'h1) ? nxt(fld_q) : fld_q;
        nc = (nf == fld_q) ? hcnt_q + 5'h1 : 5'h0;
        case (nf)
            F_ID:    nw = {144'h0, txn_q}; // RULE_07
            F_CODE:  nw = {152'h0, code_q};
            F_JHDR:  nw = {144'h0, `CCR_T_JUMP, jump_start_en_in ? `CCR_JUMP_L_F : `CCR_JUMP_L_S}; // RULE_09
            F_JLEN:  nw = {112'h0, `CCR_ST_LEN, `CCR_ST_LEN_L, jump_len_in}; // RULE_10 RULE_11
            F_KEY:   nw = {120'h0, `CCR_T_KEYSEQ, `CCR_T_KEYSEQ_L, key_seq_in,
                           `CCR_T_HMAC, `CCR_T_HMAC_L}; // RULE_08
            F_HMAC:  nw = hmac_q;
            F_SID:   nw = {146'h0, service_identifier_in};
            F_CLS:   nw = {159'h0, customer_controlled_modem_flag_in}; // RULE_20
            default: nw = 160'h0;
        endcase
        nb = (nf == F_JST) ? ser_byte : pick(nw, flen(nf), nc); // RULE_12
    end

    // ----------------------------------------
    // Main sequencer
    // ----------------------------------------
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q             <= S_IDLE;
            fld_q            <= F_ID;
            txn_q            <= 16'h0;
            code_q           <= 8'h0;
            second_q         <= 1'b0;
            is_class_q       <= 1'b0;
            retry_q          <= 8'h0;
            hcnt_q           <= 5'h0;
            hmac_q           <= 160'h0;
            tx_valid_out     <= 1'b0;
            tx_byte_out      <= 8'h0;
            tx_last_out      <= 1'b0;
            tx_is_class_out  <= 1'b0;
            retune_go_out    <= 1'b0;
            chg_busy_out     <= 1'b0;
            init_hold_out    <= 1'b0;
            reg_continue_out <= 1'b0;
            rescan_out       <= 1'b0;
        end else begin
            retune_go_out    <= 1'b0;
            reg_continue_out <= 1'b0;
            rescan_out       <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (ranging_done_in) begin
                        // RULE_17 RULE_19
                        is_class_q    <= 1'b1;
                        init_hold_out <= 1'b1; // RULE_18
                        retry_q       <= 8'h0;
                        st_q          <= S_SEND;
                        fld_q         <= F_SID;
                        tx_valid_out  <= 1'b1;
                        tx_is_class_out <= 1'b1;
                        tx_byte_out   <= {2'h0, service_identifier_in[13:8]};
                        tx_last_out   <= 1'b0;
                    end else if (chg_req_in) begin
                        txn_q        <= chg_txn_id_in;
                        // RULE_04
                        code_q       <= chg_same_chan_in ? `CCR_CC_ALREADY : `CCR_CC_DEPART;
                        second_q     <= chg_same_chan_in;
                        is_class_q   <= 1'b0;
                        chg_busy_out <= 1'b1; // RULE_05
                        hmac_q       <= hmac_in;
                        st_q         <= S_SEND;
                        fld_q        <= F_ID;
                        tx_valid_out <= 1'b1;
                        tx_is_class_out <= 1'b0;
                        tx_byte_out  <= chg_txn_id_in[15:8]; // RULE_07 RULE_03
                        tx_last_out  <= 1'b0;
                    end
                end
                S_SEND: begin
                    if (adv && tx_last_out) begin
                        tx_valid_out <= 1'b0;
                        tx_last_out  <= 1'b0;
                        hcnt_q       <= 5'h0;
                        fld_q        <= F_DONE;
                    end else if (adv && fld_q != F_DONE) begin
                        // Bytes move only on acceptance, so a stalled byte stays put
                        fld_q       <= nf;
                        hcnt_q      <= nc;
                        tx_byte_out <= nb; // RULE_22
                        tx_last_out <= (nc == flen(nf) - 5'h1) && (nxt(nf) == F_DONE);
                    end
                    if (fld_q == F_DONE) begin
                        if (is_class_q) begin
                            st_q <= S_DCIW;
                        end else if (second_q) begin
                            chg_busy_out <= 1'b0;
                            st_q         <= S_IDLE;
                        end else begin
                            retune_go_out <= 1'b1; // RULE_03
                            st_q          <= S_TUNE;
                        end
                    end
                end
                S_TUNE: begin
                    // RULE_05
                    if (retune_done_in) begin
                        if (chg_init_opt_in == `CCR_INIT_REINIT) begin
                            chg_busy_out <= 1'b0; // RULE_06
                            st_q         <= S_IDLE;
                        end else begin
                            code_q       <= `CCR_CC_ARRIVE; // RULE_06
                            second_q     <= 1'b1;
                            hmac_q       <= hmac_in;
                            st_q         <= S_SEND;
                            fld_q        <= F_ID;
                            tx_valid_out <= 1'b1;
                            tx_byte_out  <= txn_q[15:8];
                        end
                    end
                end
                S_DCIW: begin
                    // RULE_21
                    if (class_reply_in) begin
                        if (class_reply_code_in == `CCR_DCI_REJ_TEMP) begin
                            retry_q <= 8'h0;
                            st_q    <= S_SEND;
                            fld_q   <= F_SID;
                            tx_valid_out <= 1'b1;
                            tx_byte_out  <= {2'h0, service_identifier_in[13:8]};
                        end else if (class_reply_code_in == `CCR_DCI_REJ_PERM) begin
                            rescan_out    <= 1'b1;
                            init_hold_out <= 1'b0;
                            st_q          <= S_IDLE;
                        end else if (class_reply_code_in == `CCR_DCI_SUCCESS) begin
                            reg_continue_out <= 1'b1;
                            init_hold_out    <= 1'b0;
                            st_q             <= S_IDLE;
                        end
                    end else if (class_timeout_in) begin
                        if (retry_q == CLASS_RETRY_MAX) begin
                            rescan_out    <= 1'b1;
                            init_hold_out <= 1'b0;
                            st_q          <= S_IDLE;
                        end else begin
                            retry_q      <= retry_q + 8'h1;
                            st_q         <= S_SEND;
                            fld_q        <= F_SID;
                            tx_valid_out <= 1'b1;
                            tx_byte_out  <= {2'h0, service_identifier_in[13:8]};
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule // ccr_framer

/* File: ccr_framer_assertions.sv */
// Concurrent checks on the channel change reply and class request framer ports
`timescale 1ns/100ps
module ccr_framer_chk (
    input wire       clock_in,          // System clock
    input wire       arst_n_in,         // Async reset, active low
    input wire       chg_req_in,        // Change request pulse
    input wire       ranging_done_in,   // Ranging complete pulse
    input wire       class_reply_in,    // Class reply pulse
    input wire       class_timeout_in,  // Class reply timer pulse
    input wire [7:0] class_reply_code_in, // Class reply code
    input wire       tx_ready_in,       // Sink ready
    input wire       tx_valid_out,      // Byte valid
    input wire [7:0] tx_byte_out,       // Message byte
    input wire       tx_last_out,       // Last byte
    input wire       tx_is_class_out,   // Class message
    input wire       retune_go_out,     // Retune pulse
    input wire       chg_busy_out,      // Change in progress
    input wire       init_hold_out,     // Initialisation held
    input wire       reg_continue_out,  // Continue pulse
    input wire       rescan_out         // Rescan pulse
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    // Idle means no change, no hold and nothing on the wire
    wire idle = !chg_busy_out && !init_hold_out && !tx_valid_out;
    wire rep  = class_reply_in && init_hold_out;
    sequence s_class_go;
        tx_valid_out && tx_is_class_out && init_hold_out;
    endsequence
    property p_class_start;
        ranging_done_in && idle |=> s_class_go;
    endproperty
    a_class_start: assert property (p_class_start) else $error("class request late");
    property p_chg_start;
        chg_req_in && !ranging_done_in && idle |=> tx_valid_out && !tx_is_class_out && chg_busy_out;
    endproperty
    a_chg_start: assert property (p_chg_start) else $error("change reply late");
    property p_hold;
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out) && $stable(tx_last_out);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
    property p_retune_quiet;
        retune_go_out |-> chg_busy_out && !tx_valid_out ##1 !retune_go_out;
    endproperty
    a_retune_quiet: assert property (p_retune_quiet) else $error("retune pulse wrong");
    property p_hold_release;
        $fell(init_hold_out) |-> $past(class_reply_in) || $past(class_timeout_in);
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold dropped early");
    property p_continue;
        rep && class_reply_code_in == 8'h00 |-> ##[1:2] reg_continue_out;
    endproperty
    a_continue: assert property (p_continue) else $error("no continue");
    property p_rescan;
        rep && class_reply_code_in == 8'h04 |-> ##[1:2] rescan_out;
    endproperty
    a_rescan: assert property (p_rescan) else $error("no rescan");
    property p_resend;
        rep && class_reply_code_in == 8'h03 |-> ##[1:3] s_class_go;
    endproperty
    a_resend: assert property (p_resend) else $error("no resend");
endmodule // ccr_framer_chk
bind ccr_framer ccr_framer_chk i_ccr_framer_chk (.clock_in, .arst_n_in, .chg_req_in,
    .ranging_done_in, .class_reply_in, .class_timeout_in, .class_reply_code_in, .tx_ready_in, .tx_valid_out,
    .tx_byte_out, .tx_last_out, .tx_is_class_out, .retune_go_out, .chg_busy_out,
    .init_hold_out, .reg_continue_out, .rescan_out);

/* File: ccr_sink.sv */
// Upstream sink model: accepts message bytes with random stalls
`timescale 1ns/100ps
module ccr_sink (
    input  wire       clock_in,     // System clock
    input  wire       arst_n_in,    // Async reset, active low
    input  wire       tx_valid_in,  // Byte valid
    input  wire [7:0] tx_byte_in,   // Byte
    input  wire       tx_last_in,   // Last byte
    output reg        tx_ready_out  // Accepting
);
    logic [7:0] got_q[$];
    integer     n_msgs = 0;
    // Stall about a third of cycles so held bytes get exercised
    initial tx_ready_out = 1'b0;
    always @(negedge clock_in) tx_ready_out <= ($urandom % 3) != 0;
    // Collect bytes; a message ends at the last-byte marker
    always @(posedge clock_in) begin
        if (arst_n_in && tx_valid_in && tx_ready_out) begin
            got_q.push_back(tx_byte_in);
            if (tx_last_in) n_msgs <= n_msgs + 1;
        end
    end
endmodule // ccr_sink

/* File: tb_ccr_framer.sv */
// Self-checking testbench for the channel change reply and class request framer
`timescale 1ns/100ps
module tb_ccr_framer;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    reg clock_in = 0, arst_n_in = 0, chg_req_in = 0, chg_same_chan_in = 0, retune_done_in = 0;
    reg privacy_en_in = 0, jump_start_en_in = 0, ranging_done_in = 0, class_reply_in = 0;
    reg customer_controlled_modem_flag_in = 0, class_timeout_in = 0;
    reg [15:0] chg_txn_id_in = 0;
    reg [2:0] chg_init_opt_in = 0;
    reg [7:0] key_seq_in = 0, class_reply_code_in = 0;
    reg [159:0] hmac_in = 0;
    reg [31:0] jump_len_in = 0, jump_start_in = 0, jump_acc_in = 0;
    reg [13:0] service_identifier_in = 0;
    wire tx_ready_in, tx_valid_out, tx_last_out, tx_is_class_out, retune_go_out;
    wire chg_busy_out, init_hold_out, reg_continue_out, rescan_out;
    wire [7:0] tx_byte_out;
    logic [7:0] exp_q[$];
    integer n_errors = 0, checks = 0, go_cnt = 0, go_msgs = 0, cont_cnt = 0, rescan_cnt = 0;
    ccr_framer i_ccr_framer (.clock_in, .arst_n_in, .chg_req_in, .chg_txn_id_in, .chg_same_chan_in,
        .chg_init_opt_in, .retune_done_in, .privacy_en_in, .key_seq_in, .hmac_in, .jump_start_en_in,
        .jump_len_in, .jump_start_in, .jump_acc_in, .ranging_done_in, .service_identifier_in,
        .customer_controlled_modem_flag_in, .class_reply_in, .class_reply_code_in,
        .class_timeout_in, .tx_ready_in, .tx_valid_out, .tx_byte_out, .tx_last_out,
        .tx_is_class_out, .retune_go_out, .chg_busy_out, .init_hold_out, .reg_continue_out, .rescan_out);
    ccr_sink i_ccr_sink (.clock_in, .arst_n_in, .tx_valid_in(tx_valid_out), .tx_byte_in(tx_byte_out),
        .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in));
    initial forever #50 clock_in = ~clock_in;
    // Pulse counters, read at the falling edge once outputs have settled
    always @(negedge clock_in) begin
        if (retune_go_out === 1'b1) begin
            go_cnt++;
            go_msgs = i_ccr_sink.n_msgs;
        end
        if (reg_continue_out === 1'b1) cont_cnt++;
        if (rescan_out === 1'b1) rescan_cnt++;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task close_out;
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task push32(input [31:0] v);
        for (int i = 3; i >= 0; i--) exp_q.push_back(v[8*i +: 8]);
    endtask
    // Reply model: id, code, jump element on departure, privacy pair last
    task exp_reply(input [7:0] code, input jump);
        exp_q.push_back(chg_txn_id_in[15:8]);
        exp_q.push_back(chg_txn_id_in[7:0]);
        exp_q.push_back(code);
        if (jump) begin
            exp_q.push_back(8'h01); exp_q.push_back(jump_start_en_in ? 8'h10 : 8'h06);
            exp_q.push_back(8'h01); exp_q.push_back(8'h04); push32(jump_len_in);
            if (jump_start_en_in) begin
                exp_q.push_back(8'h02); exp_q.push_back(8'h08);
                push32(jump_start_in); push32(jump_acc_in);
            end
        end
        if (privacy_en_in) begin
            exp_q.push_back(8'h05); exp_q.push_back(8'h01); exp_q.push_back(key_seq_in);
            exp_q.push_back(8'h06); exp_q.push_back(8'h14);
            for (int i = 19; i >= 0; i--) exp_q.push_back(hmac_in[8*i +: 8]);
        end
    endtask
    task exp_class;
        exp_q.push_back({2'h0, service_identifier_in[13:8]});
        exp_q.push_back(service_identifier_in[7:0]);
        push32({31'h0, customer_controlled_modem_flag_in});
    endtask
    // Bounded wait for a message count, then byte-wise compare against the model
    task take_msg(input integer n);
        for (int k = 0; k < 3000 && i_ccr_sink.n_msgs < n; k++) @(negedge clock_in);
        chk("message count", n, i_ccr_sink.n_msgs);
        if (i_ccr_sink.n_msgs < n) close_out;
        chk("message length", exp_q.size(), i_ccr_sink.got_q.size());
        for (int i = 0; i < exp_q.size() && i < i_ccr_sink.got_q.size(); i++)
            chk("message byte", exp_q[i], i_ccr_sink.got_q[i]);
        exp_q.delete();
        i_ccr_sink.got_q.delete();
    endtask
    task class_pulse(input [7:0] code, input tmo);
        @(negedge clock_in);
        class_reply_code_in = code;
        class_reply_in = !tmo;
        class_timeout_in = tmo;
        @(negedge clock_in) {class_reply_in, class_timeout_in} = 2'b00;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task run_class(input [7:0] code);
        integer nm, c0, r0;
        nm = i_ccr_sink.n_msgs; c0 = cont_cnt; r0 = rescan_cnt;
        @(negedge clock_in);
        service_identifier_in = $urandom;
        customer_controlled_modem_flag_in = $urandom;
        ranging_done_in = 1;
        @(negedge clock_in) ranging_done_in = 0;
        exp_class;
        take_msg(nm + 1);
        chk("init hold", 1, init_hold_out);
        class_pulse($urandom, 1);
        exp_class;
        take_msg(nm + 2);
        class_pulse(8'h03, 0);
        exp_class;
        take_msg(nm + 3);
        class_pulse(code, 0);
        repeat (4) @(negedge clock_in);
        chk("continue pulses", c0 + (code == 8'h00), cont_cnt);
        chk("rescan pulses", r0 + (code == 8'h04), rescan_cnt);
        if (code == 8'h00) chk("init hold", 0, init_hold_out);
    endtask
    task run_change(input same, input [2:0] opt, input priv, input jse);
        integer nm, g0;
        nm = i_ccr_sink.n_msgs; g0 = go_cnt;
        @(negedge clock_in);
        chg_txn_id_in = $urandom; chg_same_chan_in = same; chg_init_opt_in = opt;
        privacy_en_in = priv; key_seq_in = $urandom; hmac_in = {5{$urandom}};
        jump_start_en_in = jse; jump_len_in = $urandom; jump_start_in = $urandom; jump_acc_in = $urandom;
        chg_req_in = 1;
        @(negedge clock_in) chg_req_in = 0;
        exp_reply(same ? 8'h03 : 8'h02, !same);
        take_msg(nm + 1);
        for (int k = 0; k < 200 && go_cnt == g0 && !same; k++) @(negedge clock_in);
        chk("retune pulses", g0 + !same, go_cnt);
        if (!same) begin
            chk("replies before retune", nm + 1, go_msgs);
            chg_req_in = 1;
            @(negedge clock_in) chg_req_in = 0;
            repeat (5) @(negedge clock_in);
            retune_done_in = 1;
            @(negedge clock_in) retune_done_in = 0;
            if (opt != 3'h0) begin
                exp_reply(8'h01, 0);
                take_msg(nm + 2);
            end
        end
        repeat (60) @(negedge clock_in);
        chk("reply total", nm + 1 + (!same && opt != 3'h0), i_ccr_sink.n_msgs);
        chk("busy", 0, chg_busy_out);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hd6e35438));
        repeat (3) @(negedge clock_in);
        arst_n_in = 1;
        chk("reset outputs", 0, {tx_valid_out, retune_go_out, chg_busy_out, init_hold_out});
        run_class(8'h00);
        run_change(0, 3'h1 + $urandom % 4, 0, 1);
        run_change(0, 3'h4, 1, 0);
        run_change(0, 3'h0, 1, 1);
        run_change(1, 3'h2, 0, 0);
        run_class(8'h04);
        close_out;
    end
endmodule // tb_ccr_framer
